/* rtl/rit_top.sv */
// Overview of operation
// - Append back-channel CRC only when enabled.
// - Rate code 000 2.5 Mbps, 001 1.5625.
// - Rate change may briefly corrupt back channel.
// - Peer address loads from forward channel.
// - Hold bit freezes peer address at write.
// - Peer alias match remaps to peer address.
// - Zero alias disables that decoder.
// - Peer auto-ack acknowledges every peer write.
// - Target alias remaps to its physical address.
// - Forward only with pass-through and match.
// - Target index selects same-index physical address.
`default_nettype none
module rit_top
  import rit_pkg::*;
(
  input  wire logic       CLK_SYS_I,
  input  wire logic       RST_I,
  input  wire logic [2:0] STRAP_RATE_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_WE_I,
  input  wire logic       REG_RE_I,
  output logic      [7:0] REG_RDATA_O,
  input  wire logic       FWD_ID_VALID_I,
  input  wire logic [6:0] FWD_ID_I,
  input  wire logic       I2C_START_I,
  input  wire logic [6:0] I2C_ADDR_I,
  input  wire logic       I2C_WRITE_I,
  output logic            FWD_VALID_O,
  output logic      [6:0] FWD_ADDR_O,
  output logic            FWD_WRITE_O,
  output logic            FWD_AUTOACK_O,
  input  wire logic [7:0] BC_DATA_I,
  input  wire logic       BC_DATA_VALID_I,
  input  wire logic       BC_FRAME_END_I,
  output logic      [7:0] BC_DATA_O,
  output logic            BC_VALID_O,
  output logic            BC_BIT_TICK_O,
  output logic            BC_RATE_SETTLE_O
);

  typedef struct packed {
    logic [7:0]       bcc;
    logic [7:0]       spare_a;
    logic [7:0]       spare_b;
    logic [6:0]       peer_addr;
    logic             hold;
    logic [6:0]       peer_alias;
    logic             peer_ack;
    logic [6:0]       tphys0;
    logic [6:0]       tphys1;
    logic [6:0]       talias0;
    logic             tack0;
    logic [6:0]       talias1;
    logic             tack1;
    logic [7:0]       rdata;
    logic [ACC_W-1:0] acc;
    logic             tick;
    logic [3:0]       settle_cnt;
    logic             settle;
    logic             fwd_vld;
    logic [6:0]       fwd_addr;
    logic             fwd_wr;
    logic             fwd_ack;
    logic [7:0]       crc;
    logic [7:0]       bc_data;
    logic             bc_vld;
  } rit_state_t;

  rit_state_t state_q;
  rit_state_t state_d;

  // One CRC-8 step over a whole byte.
  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // Phase increment for a rate code; reserved codes fall back to the fast rate.
  function automatic logic [5:0] rate_inc(input logic [2:0] code);
    return (code == RATE_SLOW) ? INC_SLOW : INC_FAST;
  endfunction

  // Three decoders in priority order: peer, target 0, target 1.
  logic [6:0] dec_alias [3];
  logic [6:0] dec_phys  [3];
  logic [2:0] dec_hit;
  logic [6:0] dec_out   [3];

  assign dec_alias[0] = state_q.peer_alias;
  assign dec_alias[1] = state_q.talias0;
  assign dec_alias[2] = state_q.talias1;
  assign dec_phys[0]  = state_q.peer_addr;
  assign dec_phys[1]  = state_q.tphys0;
  assign dec_phys[2]  = state_q.tphys1;

  for (genvar g = 0; g < 3; g++)
  begin : g_dec
    rit_alias_dec u_dec (
      .addr_i  (I2C_ADDR_I),
      .alias_i (dec_alias[g]),
      .phys_i  (dec_phys[g]),
      .hit_o   (dec_hit[g]),
      .phys_o  (dec_out[g])
    );
  end

  logic       wr_peer;
  logic       wr_bcc;
  logic       bc_on;
  logic [5:0] acc_sum;

  assign wr_peer = REG_WE_I && (REG_ADDR_I == PEER_ADDR_OFS);
  assign wr_bcc  = REG_WE_I && (REG_ADDR_I == BCC_CONFIG_OFS);
  assign bc_on   = state_q.bcc[BC_ALWAYS_BIT] | state_q.bcc[PASS_MATCH_BIT] | state_q.bcc[PASS_ALL_BIT];
  assign acc_sum = {1'b0, state_q.acc} + rate_inc(state_q.bcc[RATE_MSB:0]);

  // Next-state logic for registers, address translation and back channel.
  always_comb
  begin
    state_d        = state_q;
    state_d.fwd_vld = 1'b0;
    state_d.bc_vld  = 1'b0;
    state_d.tick    = 1'b0;

    // Register writes; reserved bit 0 of the physical address registers is dropped.
    if (REG_WE_I)
      unique case (REG_ADDR_I)
        BCC_CONFIG_OFS:  state_d.bcc = REG_WDATA_I;
        SPARE_A_OFS:     state_d.spare_a = REG_WDATA_I;
        SPARE_B_OFS:     state_d.spare_b = REG_WDATA_I;
        PEER_ADDR_OFS:   {state_d.peer_addr, state_d.hold} = REG_WDATA_I;
        PEER_ALIAS_OFS:  {state_d.peer_alias, state_d.peer_ack} = REG_WDATA_I;
        TGT_PHYS_0_OFS:  state_d.tphys0 = REG_WDATA_I[7:1];
        TGT_PHYS_1_OFS:  state_d.tphys1 = REG_WDATA_I[7:1];
        TGT_ALIAS_0_OFS: {state_d.talias0, state_d.tack0} = REG_WDATA_I;
        TGT_ALIAS_1_OFS: {state_d.talias1, state_d.tack1} = REG_WDATA_I;
        default:         state_d.bcc = state_q.bcc;
      endcase

    // Peer address capture: the forward channel loads it unless held.
    // Hold freezes value: a software write in the same cycle wins.
    if (FWD_ID_VALID_I && !state_q.hold && !wr_peer)
      state_d.peer_addr = FWD_ID_I;

    // Register reads answer one cycle later; unmapped addresses read zero.
    if (REG_RE_I)
      unique case (REG_ADDR_I)
        BCC_CONFIG_OFS:  state_d.rdata = state_q.bcc;
        SPARE_A_OFS:     state_d.rdata = state_q.spare_a;
        SPARE_B_OFS:     state_d.rdata = state_q.spare_b;
        PEER_ADDR_OFS:   state_d.rdata = {state_q.peer_addr, state_q.hold};
        PEER_ALIAS_OFS:  state_d.rdata = {state_q.peer_alias, state_q.peer_ack};
        TGT_PHYS_0_OFS:  state_d.rdata = {state_q.tphys0, 1'b0};
        TGT_PHYS_1_OFS:  state_d.rdata = {state_q.tphys1, 1'b0};
        TGT_ALIAS_0_OFS: state_d.rdata = {state_q.talias0, state_q.tack0};
        TGT_ALIAS_1_OFS: state_d.rdata = {state_q.talias1, state_q.tack1};
        default:         state_d.rdata = REG_RST;
      endcase

    // Pass-through gate: nothing leaves without the enable and a hit.
    // No match, no forward: an address outside every alias is dropped.
    if (I2C_START_I && state_q.bcc[PASS_MATCH_BIT] && (dec_hit != 3'b000))
    begin
      state_d.fwd_vld = 1'b1;
      state_d.fwd_wr  = I2C_WRITE_I;
      // Peer alias remap takes priority over the target decoders.
      // Target remap: each target carries its own physical address.
      // Same-index lookup ties alias n to physical address n.
      // Forced ack: entry auto-ack or the ack-all bit.
      if (dec_hit[0])
      begin
        state_d.fwd_addr = dec_out[0];
        state_d.fwd_ack  = I2C_WRITE_I && (state_q.peer_ack || state_q.bcc[ACK_ALL_BIT]);
      end
      else if (dec_hit[1])
      begin
        state_d.fwd_addr = dec_out[1];
        state_d.fwd_ack  = I2C_WRITE_I && (state_q.tack0 || state_q.bcc[ACK_ALL_BIT]);
      end
      else
      begin
        state_d.fwd_addr = dec_out[2];
        state_d.fwd_ack  = I2C_WRITE_I && (state_q.tack1 || state_q.bcc[ACK_ALL_BIT]);
      end
    end

    // Bit-rate tick: the accumulator overflow marks each back-channel bit.
    if (bc_on)
    begin
      state_d.acc  = acc_sum[ACC_W-1:0];
      state_d.tick = acc_sum[ACC_W];
    end

    // Settling window: flags the brief error period after a rate change.
    if (wr_bcc && (REG_WDATA_I[RATE_MSB:0] != state_q.bcc[RATE_MSB:0]))
    begin
      state_d.settle_cnt = SETTLE_CYCLES;
      state_d.settle     = 1'b1;
    end
    else if (state_q.settle_cnt != 4'h0)
    begin
      state_d.settle_cnt = state_q.settle_cnt - 4'h1;
      state_d.settle     = (state_q.settle_cnt != 4'h1);
    end

    // CRC on frames: the byte is appended at frame end only when enabled.
    if (BC_DATA_VALID_I)
    begin
      state_d.bc_data = BC_DATA_I;
      state_d.bc_vld  = 1'b1;
      state_d.crc     = crc8_step(state_q.crc, BC_DATA_I);
    end
    else if (BC_FRAME_END_I)
    begin
      state_d.crc = CRC_INIT;
      if (state_q.bcc[CRC_ON_BIT])
      begin
        state_d.bc_data = state_q.crc;
        state_d.bc_vld  = 1'b1;
      end
    end
  end

  // State register; the rate strap is sampled while reset is held.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      state_q     <= '0;
      state_q.bcc <= {BCC_CONFIG_RST[7:3], STRAP_RATE_I};
      state_q.crc <= CRC_INIT;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign REG_RDATA_O      = state_q.rdata;
  assign FWD_VALID_O      = state_q.fwd_vld;
  assign FWD_ADDR_O       = state_q.fwd_addr;
  assign FWD_WRITE_O      = state_q.fwd_wr;
  assign FWD_AUTOACK_O    = state_q.fwd_ack;
  assign BC_DATA_O        = state_q.bc_data;
  assign BC_VALID_O       = state_q.bc_vld;
  assign BC_BIT_TICK_O    = state_q.tick;
  assign BC_RATE_SETTLE_O = state_q.settle;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  sequence fast_steady;
    (state_q.bcc[RATE_MSB:0] == RATE_FAST) && bc_on && !wr_bcc;
  endsequence

  crc_appended_a: assert property (BC_FRAME_END_I && !BC_DATA_VALID_I && state_q.bcc[CRC_ON_BIT]
    |=> BC_VALID_O && (BC_DATA_O == $past(state_q.crc)))
    else $error("CRC byte missing at frame end.");
  crc_omitted_a: assert property (BC_FRAME_END_I && !BC_DATA_VALID_I && !state_q.bcc[CRC_ON_BIT]
    |=> !BC_VALID_O)
    else $error("CRC byte sent while disabled.");
  fast_rate_a: assert property ((BC_BIT_TICK_O and fast_steady)
    |=> !BC_BIT_TICK_O [*3])
    else $error("Fast rate tick came early.");
  fast_spacing_a: assert property ((BC_BIT_TICK_O and fast_steady) ##1 fast_steady [*3]
    |=> BC_BIT_TICK_O)
    else $error("Fast rate tick not every fourth cycle.");
  rate_settle_a: assert property (wr_bcc && (REG_WDATA_I[RATE_MSB:0] != state_q.bcc[RATE_MSB:0])
    |=> BC_RATE_SETTLE_O)
    else $error("Settle flag missing after rate change.");
  peer_load_a: assert property (FWD_ID_VALID_I && !state_q.hold && !wr_peer
    |=> state_q.peer_addr == $past(FWD_ID_I))
    else $error("Peer address not loaded.");
  peer_hold_a: assert property (state_q.hold && !wr_peer
    |=> $stable(state_q.peer_addr))
    else $error("Held peer address changed.");
  peer_remap_a: assert property (I2C_START_I && state_q.bcc[PASS_MATCH_BIT] && dec_hit[0]
    |=> FWD_VALID_O && (FWD_ADDR_O == $past(state_q.peer_addr)))
    else $error("Peer alias not remapped.");
  no_match_a: assert property (I2C_START_I && ((dec_hit == 3'b000) || !state_q.bcc[PASS_MATCH_BIT])
    |=> !FWD_VALID_O)
    else $error("Unmatched transaction forwarded.");
  peer_autoack_a: assert property (I2C_START_I && I2C_WRITE_I && state_q.bcc[PASS_MATCH_BIT]
    && dec_hit[0] && state_q.peer_ack |=> FWD_AUTOACK_O)
    else $error("Peer write not auto-acknowledged.");
  target_remap_a: assert property (I2C_START_I && state_q.bcc[PASS_MATCH_BIT] && !dec_hit[0] && dec_hit[1]
    |=> FWD_VALID_O && (FWD_ADDR_O == $past(state_q.tphys0)))
    else $error("Target alias not remapped.");
endmodule
`default_nettype wire

/* rtl/rit_pkg.sv */
`default_nettype none
package rit_pkg;
  // Register byte addresses.
  localparam logic [7:0] BCC_CONFIG_OFS    = 8'h58;
  localparam logic [7:0] SPARE_A_OFS       = 8'h59;
  localparam logic [7:0] SPARE_B_OFS       = 8'h5A;
  localparam logic [7:0] PEER_ADDR_OFS     = 8'h5B;
  localparam logic [7:0] PEER_ALIAS_OFS    = 8'h5C;
  localparam logic [7:0] TGT_PHYS_0_OFS    = 8'h5D;
  localparam logic [7:0] TGT_PHYS_1_OFS    = 8'h5E;
  localparam logic [7:0] TGT_ALIAS_0_OFS   = 8'h65;
  localparam logic [7:0] TGT_ALIAS_1_OFS   = 8'h66;

  // Control register field positions.
  localparam int PASS_ALL_BIT   = 7;
  localparam int PASS_MATCH_BIT = 6;
  localparam int ACK_ALL_BIT    = 5;
  localparam int BC_ALWAYS_BIT  = 4;
  localparam int CRC_ON_BIT     = 3;
  localparam int RATE_MSB       = 2;

  // Reset values; the rate field is replaced by the strap during reset.
  localparam logic [7:0] BCC_CONFIG_RST = 8'h18;
  localparam logic [7:0] REG_RST        = 8'h00;
  localparam logic [7:0] CRC_INIT       = 8'h00;
  localparam logic [7:0] CRC_POLY       = 8'h07;

  // Back-channel rate codes.
  localparam logic [2:0] RATE_FAST = 3'h0;
  localparam logic [2:0] RATE_SLOW = 3'h1;

  // Bit-rate generator: a 5-bit phase accumulator gives both rates exactly.
  localparam int          CLK_HZ       = 10000000;
  localparam int          FAST_BPS     = 2500000;
  localparam int          SLOW_BPS     = 1562500;
  localparam int          ACC_W        = 5;
  localparam int          ACC_MOD      = 32;
  localparam logic [5:0]  INC_FAST     = 6'(FAST_BPS * ACC_MOD / CLK_HZ);
  localparam logic [5:0]  INC_SLOW     = 6'(SLOW_BPS * ACC_MOD / CLK_HZ);

  // Settling window after a rate change, in microseconds and in cycles.
  localparam int          SETTLE_US     = 1;
  localparam logic [3:0]  SETTLE_CYCLES = 4'(SETTLE_US * (CLK_HZ / 1000000));
endpackage
`default_nettype wire

/* rtl/rit_alias_dec.sv */
`default_nettype none
module rit_alias_dec
  import rit_pkg::*;
(
  input  wire logic [6:0] addr_i,
  input  wire logic [6:0] alias_i,
  input  wire logic [6:0] phys_i,
  output logic            hit_o,
  output logic [6:0]      phys_o
);
  // Zero alias disables: address zero never matches here.
  assign hit_o  = (alias_i != 7'h00) && (addr_i == alias_i);
  assign phys_o = phys_i;
endmodule
`default_nettype wire

/* bench/rit_peer_model.sv */
`default_nettype none
// Behavioural remote serializer: it sends its identity and back-channel bytes.
module rit_peer_model (
  input  wire logic       clk_i,
  output logic            id_valid_o,
  output logic      [6:0] id_o,
  output logic      [7:0] bc_data_o,
  output logic            bc_valid_o,
  output logic            bc_end_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle lines show the inverse of the last value, so no stale copy can match.
  initial
  begin
    id_valid_o = 1'b0;
    id_o = 7'h00;
    bc_data_o = 8'h00;
    bc_valid_o = 1'b0;
    bc_end_o = 1'b0;
  end

  task automatic send_id(input logic [6:0] id);
    @(negedge clk_i);
    id_o = id;
    id_valid_o = 1'b1;
    @(negedge clk_i);
    id_valid_o = 1'b0;
    id_o = ~id;
  endtask

  // One byte of back-channel traffic, one cycle wide.
  task automatic send_byte(input logic [7:0] b);
    @(negedge clk_i);
    bc_data_o = b;
    bc_valid_o = 1'b1;
    @(negedge clk_i);
    bc_valid_o = 1'b0;
    bc_data_o = ~b;
  endtask

  // A frame end is a cycle with no byte.
  task automatic end_frame();
    @(negedge clk_i);
    bc_end_o = 1'b1;
    @(negedge clk_i);
    bc_end_o = 1'b0;
  endtask
endmodule
`default_nettype wire

/* bench/rit_top_tb_top.sv */
`default_nettype none
module rit_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rit_pkg::*;

  typedef struct packed {
    logic [6:0] a;
    logic       w;
    logic       v;
    logic [6:0] e;
    logic       k;
  } rit_row_t;

  // Target, write, forwarded, remapped address, forced ack.
  localparam rit_row_t ROWS [6] = '{'{7'h30, 1'b1, 1'b1, 7'h12, 1'b1}, '{7'h30, 1'b0, 1'b1, 7'h12, 1'b0},
    '{7'h40, 1'b1, 1'b1, 7'h21, 1'b0}, '{7'h41, 1'b0, 1'b1, 7'h22, 1'b0},
    '{7'h55, 1'b1, 1'b0, 7'h00, 1'b0}, '{7'h12, 1'b1, 1'b0, 7'h00, 1'b0}};

  logic       clk;
  logic       rst;
  logic [2:0] strap;
  logic [7:0] ra;
  logic [7:0] rw;
  logic       we;
  logic       re;
  logic       st;
  logic [6:0] ia;
  logic       iw;
  wire  [7:0] rdata;
  wire        fv;
  wire  [6:0] fa;
  wire        fw;
  wire        fk;
  wire  [7:0] bd;
  wire        bv;
  wire        tick;
  wire        settle;
  wire        idv;
  wire  [6:0] id;
  wire  [7:0] pd;
  wire        pv;
  wire        pe;
  int         n_errors = 0;
  int         num_checks = 0;
  logic [7:0] crc;
  int         n;

  rit_top u_rit_top (.CLK_SYS_I(clk), .RST_I(rst), .STRAP_RATE_I(strap), .REG_ADDR_I(ra), .REG_WDATA_I(rw),
    .REG_WE_I(we), .REG_RE_I(re), .REG_RDATA_O(rdata), .FWD_ID_VALID_I(idv), .FWD_ID_I(id), .I2C_START_I(st),
    .I2C_ADDR_I(ia), .I2C_WRITE_I(iw), .FWD_VALID_O(fv), .FWD_ADDR_O(fa), .FWD_WRITE_O(fw), .FWD_AUTOACK_O(fk),
    .BC_DATA_I(pd), .BC_DATA_VALID_I(pv), .BC_FRAME_END_I(pe), .BC_DATA_O(bd), .BC_VALID_O(bv),
    .BC_BIT_TICK_O(tick), .BC_RATE_SETTLE_O(settle));

  rit_peer_model u_rit_peer_model (.clk_i(clk), .id_valid_o(idv), .id_o(id), .bc_data_o(pd), .bc_valid_o(pv),
    .bc_end_o(pe));

  // Free-running 10 MHz system clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Single comparison; a 1-bit result widens with zeros and an unknown still mismatches.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    ra = a;
    rw = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask

  // Read data is registered and is looked at in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    ra = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    chk(rdata, exp);
  endtask

  task automatic i2c(input rit_row_t r);
    @(negedge clk);
    ia = r.a;
    iw = r.w;
    st = 1'b1;
    @(negedge clk);
    st = 1'b0;
    chk(fv, r.v);
    if (r.v)
    begin
      chk(fa, r.e);
      chk(fw, r.w);
      chk(fk, r.k);
    end
  endtask

  // Reference CRC-8, worked out bit by bit and independent of the block.
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
    return r;
  endfunction

  // Ticks over 64 cycles; both rates divide that span exactly, whatever the phase.
  task automatic ticks(input int exp);
    n = 0;
    repeat (64)
    begin
      @(posedge clk);
      #1 n += int'(tick);
    end
    chk(8'(n), 8'(exp));
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A hang is cut short well past the expected run of a few hundred cycles.
  initial
  begin
    #1000000;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    {strap, ra, rw, we, re, st, ia, iw} = '0;
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    rd(BCC_CONFIG_OFS, 8'h18);
    rd(PEER_ADDR_OFS, 8'h00);
    rd(PEER_ALIAS_OFS, 8'h00);
    rd(TGT_PHYS_1_OFS, 8'h00);
    rd(8'h70, 8'h00);
    wr(SPARE_A_OFS, 8'hA5);
    rd(SPARE_A_OFS, 8'hA5);
    wr(BCC_CONFIG_OFS, 8'h58);
    wr(PEER_ADDR_OFS, 8'h24);
    wr(PEER_ALIAS_OFS, 8'h61);
    wr(TGT_PHYS_0_OFS, 8'h43);
    wr(TGT_PHYS_1_OFS, 8'h44);
    wr(TGT_ALIAS_0_OFS, 8'h80);
    wr(TGT_ALIAS_1_OFS, 8'h82);
    rd(TGT_PHYS_0_OFS, 8'h42);
    foreach (ROWS[i]) i2c(ROWS[i]);
    wr(BCC_CONFIG_OFS, 8'h18);
    i2c('{7'h40, 1'b1, 1'b0, 7'h00, 1'b0});
    wr(BCC_CONFIG_OFS, 8'h58);
    wr(TGT_ALIAS_1_OFS, 8'h00);
    i2c('{7'h00, 1'b1, 1'b0, 7'h00, 1'b0});
    i2c('{7'h41, 1'b1, 1'b0, 7'h00, 1'b0});
    u_rit_peer_model.send_id(7'h2A);
    rd(PEER_ADDR_OFS, 8'h54);
    i2c('{7'h30, 1'b1, 1'b1, 7'h2A, 1'b1});
    wr(PEER_ADDR_OFS, 8'h23);
    u_rit_peer_model.send_id(7'h33);
    rd(PEER_ADDR_OFS, 8'h23);
    u_rit_peer_model.send_byte(8'hA5);
    chk(bv, 1'b1);
    chk(bd, 8'hA5);
    u_rit_peer_model.send_byte(8'h3C);
    crc = crc8(crc8(CRC_INIT, 8'hA5), 8'h3C);
    u_rit_peer_model.end_frame();
    chk(bv, 1'b1);
    chk(bd, crc);
    wr(BCC_CONFIG_OFS, 8'h50);
    u_rit_peer_model.end_frame();
    chk(bv, 1'b0);
    wr(BCC_CONFIG_OFS, 8'h70);
    i2c('{7'h40, 1'b1, 1'b1, 7'h21, 1'b1});
    ticks(16);
    wr(BCC_CONFIG_OFS, 8'h71);
    // The settle flag stands for ten cycles: check its last high cycle and its first low one.
    repeat (9) @(negedge clk);
    chk(settle, 1'b1);
    @(negedge clk);
    chk(settle, 1'b0);
    ticks(10);
    strap = RATE_SLOW;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(BCC_CONFIG_OFS, 8'h19);
    rd(PEER_ADDR_OFS, 8'h00);
    ticks(10);
    wrap_up();
  end
endmodule
`default_nettype wire
